/* File: rtl/drt_counter.sv */
`timescale 1ns/1ps
`default_nettype none

module drt_counter #(
    parameter int unsigned W = 8
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // control
    input  wire logic         start,
    input  wire logic         stop,
    input  wire logic         tick,
    input  wire logic         repeat_en,
    input  wire logic [W-1:0] init,
    // state
    output logic      [W-1:0] count_r,
    output logic              run_r,
    output logic              ovf
);

    logic adv;

    assign adv = tick && run_r && !start && !stop;
    assign ovf = adv && (&count_r);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_r <= '0;
        end else if (start) begin
            count_r <= init;
        end else if (adv) begin
            if (&count_r) begin
                count_r <= repeat_en ? init : '0;
            end else begin
                count_r <= W'(count_r + 1'b1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            run_r <= 1'b0;
        end else if (start) begin
            run_r <= 1'b1;
        end else if (stop) begin
            run_r <= 1'b0;
        end else if (ovf && !repeat_en) begin
            run_r <= 1'b0;
        end
    end

    chk_repeat_reload: assert property (
        @(posedge clk) disable iff (!rst_b)
        ovf && repeat_en |=> count_r == $past(init) && run_r)
        else $error("repeat overflow did not reload");

    chk_single_stop: assert property (
        @(posedge clk) disable iff (!rst_b)
        ovf && !repeat_en |=> !run_r && count_r == '0 ##1 !run_r)
        else $error("single overflow did not stop");

    chk_count_step: assert property (
        @(posedge clk) disable iff (!rst_b)
        adv && !(&count_r) |=> count_r == W'($past(count_r) + 1'b1))
        else $error("counter did not advance by one");

endmodule : drt_counter

`default_nettype wire

/* File: rtl/drt_pkg.sv */
package drt_pkg;

    // peripheral table 0 indices
    localparam logic [3:0] DRT_IDX_T1_CTRL  = 4'h3;
    localparam logic [3:0] DRT_IDX_T1_VAL   = 4'h4;
    localparam logic [3:0] DRT_IDX_T2_CTRL  = 4'h5;
    localparam logic [3:0] DRT_IDX_T2_VAL   = 4'h6;
    localparam logic [3:0] DRT_IDX_T2_HI    = 4'hb;

    // control field positions
    localparam int         DRT_B_START      = 0;
    localparam int         DRT_B_REPEAT     = 1;
    localparam int         DRT_B_HALT       = 2;
    localparam int         DRT_B_EXT        = 2;
    localparam int         DRT_B_MASK       = 3;

    // reset values
    localparam logic [3:0] DRT_CTRL_RST     = 4'h0;

    // widths and timing
    localparam int         DRT_T1_W         = 8;
    localparam int         DRT_T2_W         = 12;
    localparam int         DRT_INSTR_CLKS   = 6;
    localparam int         DRT_PRESC_DIV    = 2;
    localparam int         DRT_PRESC_CNT_W  = 16;

    typedef struct packed {
        logic       sel;
        logic       wr;
        logic       rd;
        logic [3:0] idx;
        logic       y_lsb;
        logic [3:0] wdata;
    } drt_req_t;

    typedef struct packed {
        logic [3:0] rdata;
        logic       rvalid;
    } drt_rsp_t;

endpackage : drt_pkg

/* File: rtl/drt_timer.sv */
// Behaviour
// - timer one 8 bits, timer two 12
// - registers at indices 3,4,5,6,11
// - prescaler halt freezes timer one and internally clocked timer two, keeps values
// - prescaler restart clears its divider
// - prescaler tick also feeds other units
// - timer one initial value nibble writes
// - timer one read returns live count
// - counter reads are not latched
// - timer two mask bit clear freezes counter
// - timer two control reads stored bits
// - timer two initial value nibble writes
// - timer two live count nibble reads
// - overflow reloads in repeat, stops single
// - start loads latest initial value
// - overflow flag needs enable, start clears
// - timer one control bit 2 halts prescaler
`timescale 1ns/1ps
`default_nettype none

module drt_timer #(
    parameter int unsigned PRESC_DIV = drt_pkg::DRT_PRESC_DIV
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    // peripheral register access
    input  wire drt_pkg::drt_req_t req,
    output var  drt_pkg::drt_rsp_t rsp,
    // external count pin
    input  wire logic              external_count_input,
    // interrupt enables from the interrupt controller
    input  wire logic              t1_irq_en,
    input  wire logic              t2_irq_en,
    // events and status
    output logic                   t1_ovf_flag,
    output logic                   t2_ovf_flag,
    output logic                   t1_irq_req,
    output logic                   t2_irq_req,
    output logic                   presc_tick
);
    import drt_pkg::*;

    localparam int unsigned PRESC_CYC = DRT_INSTR_CLKS * PRESC_DIV;
    localparam logic [DRT_PRESC_CNT_W-1:0] PRESC_LAST =
        DRT_PRESC_CNT_W'(PRESC_CYC - 1);

    logic [1:0]                 rst_sync_r;
    logic                       rst_int_b;
    logic [3:0]                 t1_ctrl_r;
    logic [3:0]                 t2_ctrl_r;
    logic [DRT_T1_W-1:0]        t1_init_r;
    logic [DRT_T2_W-1:0]        t2_init_r;
    logic [DRT_PRESC_CNT_W-1:0] presc_cnt_r;
    logic [2:0]                 ext_sync_r;
    logic                       ext_lvl_r;
    logic                       ext_edge_r;
    logic                       wr_t1c;
    logic                       wr_t1v;
    logic                       wr_t2c;
    logic                       wr_t2v;
    logic                       wr_t2h;
    logic                       rd_any;
    logic                       halt;
    logic                       t1_start;
    logic                       t1_stop;
    logic                       t2_start;
    logic                       t2_stop;
    logic                       t2_tick;
    logic [DRT_T1_W-1:0]        t1_count;
    logic [DRT_T2_W-1:0]        t2_count;
    logic                       t1_run;
    logic                       t2_run;
    logic                       t1_ovf;
    logic                       t2_ovf;
    logic [3:0]                 rdata_nxt;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_int_b = rst_sync_r[1];

    assign wr_t1c = req.sel && req.wr && (req.idx == DRT_IDX_T1_CTRL);
    assign wr_t1v = req.sel && req.wr && (req.idx == DRT_IDX_T1_VAL);
    assign wr_t2c = req.sel && req.wr && (req.idx == DRT_IDX_T2_CTRL);
    assign wr_t2v = req.sel && req.wr && (req.idx == DRT_IDX_T2_VAL);
    assign wr_t2h = req.sel && req.wr && (req.idx == DRT_IDX_T2_HI);
    assign rd_any = req.sel && req.rd;

    always_ff @(posedge clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            t1_ctrl_r <= DRT_CTRL_RST;
            t2_ctrl_r <= DRT_CTRL_RST;
        end else begin
            if (wr_t1c) begin
                t1_ctrl_r <= req.wdata;
            end
            if (wr_t2c) begin
                t2_ctrl_r <= req.wdata;
            end
        end
    end

    // start only when idle
    // rewriting control while running (mask, mode) must not reload
    assign t1_start = wr_t1c && req.wdata[DRT_B_START] && !t1_run;
    assign t1_stop  = wr_t1c && !req.wdata[DRT_B_START];
    assign t2_start = wr_t2c && req.wdata[DRT_B_START] && !t2_run;
    assign t2_stop  = wr_t2c && !req.wdata[DRT_B_START];

    always_ff @(posedge clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            t1_init_r <= '0;
        end else if (wr_t1v) begin
            if (req.y_lsb) begin
                t1_init_r[7:4] <= req.wdata;
            end else begin
                t1_init_r[3:0] <= req.wdata;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            t2_init_r <= '0;
        end else if (wr_t2h) begin
            t2_init_r[11:8] <= req.wdata;
        end else if (wr_t2v) begin
            if (req.y_lsb) begin
                t2_init_r[7:4] <= req.wdata;
            end else begin
                t2_init_r[3:0] <= req.wdata;
            end
        end
    end

    assign halt = t1_ctrl_r[DRT_B_HALT];

    always_ff @(posedge clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            presc_cnt_r <= '0;
        end else if (halt || presc_cnt_r == PRESC_LAST) begin
            presc_cnt_r <= '0;
        end else begin
            presc_cnt_r <= DRT_PRESC_CNT_W'(presc_cnt_r + 1'b1);
        end
    end

    always_ff @(posedge clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            presc_tick <= 1'b0;
        end else begin
            presc_tick <= !halt && (presc_cnt_r == PRESC_LAST);
        end
    end

    // three-stage pin sampling
    // level accepted only when stages two and three agree (glitch filter)
    always_ff @(posedge clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            ext_sync_r <= 3'h0;
            ext_lvl_r  <= 1'b0;
            ext_edge_r <= 1'b0;
        end else begin
            ext_sync_r <= {ext_sync_r[1:0], external_count_input};
            if (ext_sync_r[1] == ext_sync_r[2]) begin
                ext_lvl_r <= ext_sync_r[2];
            end
            ext_edge_r <= (ext_sync_r[1] == ext_sync_r[2])
                          && ext_sync_r[2] && !ext_lvl_r;
        end
    end

    assign t2_tick = t2_ctrl_r[DRT_B_MASK]
                     && (t2_ctrl_r[DRT_B_EXT] ? ext_edge_r : presc_tick);

    drt_counter #(.W(DRT_T1_W)) u_t1 (
        .clk       (clk),
        .rst_b     (rst_int_b),
        .start     (t1_start),
        .stop      (t1_stop),
        .tick      (presc_tick),
        .repeat_en (t1_ctrl_r[DRT_B_REPEAT]),
        .init      (t1_init_r),
        .count_r   (t1_count),
        .run_r     (t1_run),
        .ovf       (t1_ovf)
    );

    drt_counter #(.W(DRT_T2_W)) u_t2 (
        .clk       (clk),
        .rst_b     (rst_int_b),
        .start     (t2_start),
        .stop      (t2_stop),
        .tick      (t2_tick),
        .repeat_en (t2_ctrl_r[DRT_B_REPEAT]),
        .init      (t2_init_r),
        .count_r   (t2_count),
        .run_r     (t2_run),
        .ovf       (t2_ovf)
    );

    always_ff @(posedge clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            t1_ovf_flag <= 1'b0;
            t2_ovf_flag <= 1'b0;
            t1_irq_req  <= 1'b0;
            t2_irq_req  <= 1'b0;
        end else begin
            t1_irq_req <= t1_ovf && t1_irq_en;
            t2_irq_req <= t2_ovf && t2_irq_en;
            if (t1_ovf && t1_irq_en) begin
                t1_ovf_flag <= 1'b1;
            end else if (t1_start) begin
                t1_ovf_flag <= 1'b0;
            end
            if (t2_ovf && t2_irq_en) begin
                t2_ovf_flag <= 1'b1;
            end else if (t2_start) begin
                t2_ovf_flag <= 1'b0;
            end
        end
    end

    // live count, no snapshot
    // multi-nibble reads can tear while counting; software must cope
    always_comb begin
        rdata_nxt = 4'h0;
        case (req.idx)
            DRT_IDX_T1_CTRL: rdata_nxt = t1_ctrl_r;
            DRT_IDX_T1_VAL:  rdata_nxt = req.y_lsb ? t1_count[7:4]
                                                   : t1_count[3:0];
            DRT_IDX_T2_CTRL: rdata_nxt = t2_ctrl_r;
            DRT_IDX_T2_VAL:  rdata_nxt = req.y_lsb ? t2_count[7:4]
                                                   : t2_count[3:0];
            DRT_IDX_T2_HI:   rdata_nxt = t2_count[11:8];
            default:         rdata_nxt = 4'h0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            rsp <= '0;
        end else begin
            rsp.rvalid <= rd_any;
            rsp.rdata  <= rd_any ? rdata_nxt : 4'h0;
        end
    end

    chk_start_load: assert property (
        @(posedge clk) disable iff (!rst_int_b)
        t1_start |=> t1_count == $past(t1_init_r) && t1_run)
        else $error("start did not load initial value");

    chk_halt_freeze: assert property (
        @(posedge clk) disable iff (!rst_int_b)
        halt && $past(halt) && !t1_start |=> $stable(t1_count))
        else $error("timer one moved while prescaler halted");

    chk_presc_clear: assert property (
        @(posedge clk) disable iff (!rst_int_b)
        halt |=> presc_cnt_r == '0 && !presc_tick)
        else $error("prescaler divider not cleared on halt");

    chk_mask_hold: assert property (
        @(posedge clk) disable iff (!rst_int_b)
        !t2_ctrl_r[DRT_B_MASK] && !t2_start |=> $stable(t2_count))
        else $error("timer two moved while masked");

    chk_flag_set: assert property (
        @(posedge clk) disable iff (!rst_int_b)
        t1_ovf |=> t1_ovf_flag == $past(t1_irq_en)
                   && t1_irq_req == $past(t1_irq_en))
        else $error("overflow flag does not follow enable");

    chk_flag_clear: assert property (
        @(posedge clk) disable iff (!rst_int_b)
        t2_start && !t2_ovf |=> !t2_ovf_flag)
        else $error("start did not clear overflow flag");

    chk_t1_read: assert property (
        @(posedge clk) disable iff (!rst_int_b)
        rd_any && req.idx == DRT_IDX_T1_VAL && req.y_lsb
        |=> rsp.rvalid && rsp.rdata == $past(t1_count[7:4]))
        else $error("timer one upper nibble read wrong");

    chk_t2_hi_read: assert property (
        @(posedge clk) disable iff (!rst_int_b)
        rd_any && req.idx == DRT_IDX_T2_HI
        |=> rsp.rdata == $past(t2_count[11:8]))
        else $error("timer two top nibble read wrong");

    chk_ctrl_read: assert property (
        @(posedge clk) disable iff (!rst_int_b)
        rd_any && req.idx == DRT_IDX_T2_CTRL
        |=> rsp.rdata == $past(t2_ctrl_r))
        else $error("timer two control read wrong");

    chk_ext_edge: assert property (
        @(posedge clk) disable iff (!rst_int_b)
        ext_edge_r |=> !ext_edge_r ##1 !ext_edge_r)
        else $error("external edge counted more than once");

endmodule : drt_timer

`default_nettype wire

/* File: verif/drt_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none

module drt_cpu_model (
    // clock
    input  wire logic              clk,
    // peripheral table access
    output var  drt_pkg::drt_req_t req,
    input  wire drt_pkg::drt_rsp_t rsp
);
    import drt_pkg::*;

    initial req = '0;

    // one access: set after a falling edge, held over the taking edge,
    // answer taken one cycle later; idle lines show inverted values so a
    // design that looks at them while deselected is caught
    task automatic access(input logic w, input logic [3:0] i,
                          input logic y, input logic [3:0] d,
                          output drt_rsp_t r);
        @(negedge clk);
        // field order sel, wr, rd, idx, y_lsb, wdata
        req <= {1'b1, w, !w, i, y, d};
        @(negedge clk);
        r = rsp;
        req <= {1'b0, 1'b0, 1'b0, ~i, ~y, ~d};
    endtask : access
endmodule : drt_cpu_model

`default_nettype wire

/* File: verif/dual_reload_timer_prescaler_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module dual_reload_timer_prescaler_tb;
    import drt_pkg::*;

    typedef struct packed {
        logic       w;
        logic [3:0] i;
        logic       y;
        logic [3:0] d;
        logic [3:0] e;
    } drt_row_t;

    logic     clk, rst_b, ext_in, t1_en, t2_en;
    logic     t1_flag, t2_flag, t1_irq, t2_irq, tick;
    drt_req_t req;
    drt_rsp_t rsp;
    int       error_cnt, cmp_count, irq1_cnt, irq1_seen, irq2_cnt;
    int       cyc, last_tick, tick_gap, n;

    // write-then-read rows; w=0 rows only read
    drt_row_t rows[8] = '{
        {1'b0, 4'h3, 1'b0, 4'h0, 4'h0}, {1'b0, 4'h5, 1'b0, 4'h0, 4'h0},
        {1'b0, 4'h4, 1'b1, 4'h0, 4'h0}, {1'b1, 4'h3, 1'b0, 4'h4, 4'h4},
        {1'b1, 4'h5, 1'b0, 4'ha, 4'ha}, {1'b1, 4'h5, 1'b0, 4'h0, 4'h0},
        {1'b1, 4'h7, 1'b0, 4'hf, 4'h0}, {1'b1, 4'h3, 1'b0, 4'h0, 4'h0}};

    drt_timer #(.PRESC_DIV(1)) dut (
        .clk(clk), .rst_b(rst_b), .req(req), .rsp(rsp),
        .external_count_input(ext_in), .t1_irq_en(t1_en),
        .t2_irq_en(t2_en), .t1_ovf_flag(t1_flag), .t2_ovf_flag(t2_flag),
        .t1_irq_req(t1_irq), .t2_irq_req(t2_irq), .presc_tick(tick));

    drt_cpu_model cpu (.clk(clk), .req(req), .rsp(rsp));

    always #12.5 clk = ~clk;

    always @(posedge clk) begin
        cyc++;
        if (tick === 1'b1) begin
            tick_gap = cyc - last_tick;
            last_tick = cyc;
        end
        if (t1_irq === 1'b1) irq1_cnt++;
        if (t2_irq === 1'b1) irq2_cnt++;
    end

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: saw %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] i, input logic y,
                      input logic [3:0] d);
        drt_rsp_t r;
        cpu.access(1'b1, i, y, d, r);
    endtask : wr

    task automatic rd(input logic [3:0] i, input logic y,
                      input logic [3:0] e);
        drt_rsp_t r;
        cpu.access(1'b0, i, y, 4'h0, r);
        chk({11'h0, r.rvalid}, 12'h1);
        chk({8'h0, r.rdata}, {8'h0, e});
    endtask : rd

    // held high and low long enough for the pin synchroniser
    task automatic pulse(input int k);
        repeat (k) begin
            @(negedge clk) ext_in = 1'b1;
            repeat (4) @(negedge clk);
            ext_in = 1'b0;
            repeat (4) @(negedge clk);
        end
        repeat (6) @(negedge clk);
    endtask : pulse

    task automatic give_verdict;
        $display("errors %0d, comparisons %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict

    initial begin
        #500000;
        error_cnt++;
        $display("ERROR %0t: run did not finish", $time);
        give_verdict();
    end

    initial begin
        clk = 0; rst_b = 0; ext_in = 0; t1_en = 1; t2_en = 1;
        repeat (6) @(negedge clk);
        rst_b = 1;
        repeat (3) @(negedge clk);
        foreach (rows[k]) begin
            if (rows[k].w) wr(rows[k].i, rows[k].y, rows[k].d);
            rd(rows[k].i, rows[k].y, rows[k].e);
        end
        repeat (20) @(negedge clk);
        chk(tick_gap[11:0], 12'h6);
        // timer one, loaded while the prescaler is halted
        wr(4'h4, 1'b1, 4'hf);
        wr(4'h4, 1'b0, 4'he);
        wr(4'h3, 1'b0, 4'h4);
        wr(4'h3, 1'b0, 4'h5);
        repeat (20) @(negedge clk);
        rd(4'h4, 1'b1, 4'hf);
        rd(4'h4, 1'b0, 4'he);
        chk({11'h0, t1_flag}, 12'h0);
        wr(4'h3, 1'b0, 4'h0);
        wr(4'h3, 1'b0, 4'h1);
        for (n = 0; n < 20 && t1_flag !== 1'b1; n++) @(negedge clk);
        chk({11'h0, t1_flag}, 12'h1);
        // the request pulse is counted at the next rising edge
        @(negedge clk);
        chk(irq1_cnt[11:0], 12'h1);
        chk(n[11:0] > 12'h7, 12'h1);
        repeat (20) @(negedge clk);
        rd(4'h4, 1'b1, 4'h0);
        rd(4'h4, 1'b0, 4'h0);
        // repeat mode with interrupt disabled
        t1_en = 0;
        irq1_seen = irq1_cnt;
        wr(4'h3, 1'b0, 4'h2);
        wr(4'h3, 1'b0, 4'h3);
        @(negedge clk);
        chk({11'h0, t1_flag}, 12'h0);
        repeat (40) @(negedge clk);
        chk({11'h0, t1_flag}, 12'h0);
        chk(irq1_cnt[11:0], irq1_seen[11:0]);
        rd(4'h4, 1'b1, 4'hf);
        // timer two on the external pin, start sequence
        wr(4'h6, 1'b1, 4'h3);
        wr(4'h6, 1'b0, 4'h4);
        wr(4'hb, 1'b0, 4'h5);
        wr(4'h5, 1'b0, 4'he);
        wr(4'h5, 1'b0, 4'hf);
        rd(4'h5, 1'b0, 4'hf);
        pulse(3);
        rd(4'hb, 1'b0, 4'h5);
        rd(4'h6, 1'b1, 4'h3);
        rd(4'h6, 1'b0, 4'h7);
        wr(4'h5, 1'b0, 4'h7);
        pulse(2);
        rd(4'h6, 1'b0, 4'h7);
        wr(4'h5, 1'b0, 4'hf);
        pulse(1);
        rd(4'h6, 1'b0, 4'h8);
        // timer two single mode on the internal clock, near overflow
        wr(4'h5, 1'b0, 4'h8);
        wr(4'h6, 1'b1, 4'hf);
        wr(4'h6, 1'b0, 4'he);
        wr(4'hb, 1'b0, 4'hf);
        wr(4'h5, 1'b0, 4'h9);
        rd(4'h5, 1'b0, 4'h9);
        for (n = 0; n < 20 && t2_flag !== 1'b1; n++) @(negedge clk);
        chk({11'h0, t2_flag}, 12'h1);
        @(negedge clk);
        chk(irq2_cnt[11:0], 12'h1);
        rd(4'hb, 1'b0, 4'h0);
        rd(4'h6, 1'b0, 4'h0);
        // reset again in mid-run
        @(negedge clk) rst_b = 0;
        repeat (6) @(negedge clk);
        rst_b = 1;
        repeat (3) @(negedge clk);
        rd(4'h3, 1'b0, 4'h0);
        rd(4'h5, 1'b0, 4'h0);
        chk({10'h0, t1_flag, t2_flag}, 12'h0);
        give_verdict();
    end
endmodule : dual_reload_timer_prescaler_tb

`default_nettype wire
